// >>> logic/sdsb_builder.v
// health-data sector builder: threshold sector, attribute entries, usage counters, health verdict
`timescale 1ns/1ps
`default_nettype none
`include "sdsb_regs.vh"

module sdsb_builder #(
  parameter [7:0] THR_SPARE = `SDSB_THR_SPARE_TYP,
  parameter [7:0] THR_ERASE = `SDSB_THR_ERASE_TYP,
  parameter READ_W = 48,
  parameter POWER_W = 32,
  parameter LBA_W = 64,
  parameter LBA_AW = 16
) (
  input wire clk,
  input wire resetn,
  input wire cmd_valid,
  input wire [7:0] cmd_feature,
  input wire [7:0] cmd_cyl_lo,
  input wire [7:0] cmd_cyl_hi,
  input wire attr_req,
  input wire [2:0] attr_sel,
  output reg busy_reg,
  output reg cmd_reject_reg,
  output reg [7:0] out_data_reg,
  output reg out_valid_reg,
  output reg out_last_reg,
  input wire out_ready,
  input wire flash_read_pulse,
  input wire power_on_pulse,
  input wire lba_write_valid,
  input wire [LBA_AW-1:0] lba_write_count,
  input wire lba_read_valid,
  input wire [LBA_AW-1:0] lba_read_count,
  input wire [7:0] spare_value,
  input wire [7:0] erase_value,
  input wire health_req,
  output reg health_done_reg,
  output reg health_exceeded_reg,
  output reg [7:0] health_cyl_lo_reg,
  output reg [7:0] health_cyl_hi_reg
);

  // ****************************************
  // states
  // ****************************************
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_FETCH = 4'b0010;
  localparam [3:0] ST_LOAD = 4'b0100;
  localparam [3:0] ST_SEND = 4'b1000;

  reg [3:0] state_reg;
  reg [8:0] idx_reg;
  reg thr_mode_reg;
  reg [2:0] sel_reg;
  reg [7:0] sum_reg;

  wire [READ_W-1:0] read_count;
  wire [POWER_W-1:0] power_count;
  wire [LBA_W-1:0] lba_wr_total;
  wire [LBA_W-1:0] lba_rd_total;
  wire [7:0] rom_data;

  // ****************************************
  // usage counters
  // ****************************************
  sdsb_counter #(.W(READ_W), .AW(1)) u_read_cnt (
    .clk(clk),
    .resetn(resetn),
    .inc_en(flash_read_pulse),
    .inc_amt(1'b1),
    .count_reg(read_count)
  );

  sdsb_counter #(.W(POWER_W), .AW(1)) u_power_cnt (
    .clk(clk),
    .resetn(resetn),
    .inc_en(power_on_pulse),
    .inc_amt(1'b1),
    .count_reg(power_count)
  );

  sdsb_counter #(.W(LBA_W), .AW(LBA_AW)) u_lba_wr_cnt (
    .clk(clk),
    .resetn(resetn),
    .inc_en(lba_write_valid),
    .inc_amt(lba_write_count),
    .count_reg(lba_wr_total)
  );

  sdsb_counter #(.W(LBA_W), .AW(LBA_AW)) u_lba_rd_cnt (
    .clk(clk),
    .resetn(resetn),
    .inc_en(lba_read_valid),
    .inc_amt(lba_read_count),
    .count_reg(lba_rd_total)
  );

  // ****************************************
  // threshold table
  // ****************************************
  sdsb_thr_rom #(.THR_SPARE(THR_SPARE), .THR_ERASE(THR_ERASE)) u_thr_rom (
    .clk(clk),
    .resetn(resetn),
    .addr(idx_reg),
    .rd_data_reg(rom_data)
  );

  // ****************************************
  // attribute entry bytes
  // ****************************************
  reg [47:0] raw_sel;
  reg [7:0] attr_id;
  reg [7:0] attr_byte;
  wire [47:0] raw_shift;
  wire [3:0] raw_pos;

  always @* begin
    raw_sel = 48'h0;
    attr_id = 8'h00;
    case (sel_reg)
      3'h0: begin
        attr_id = `SDSB_ID_READS;
        raw_sel = read_count[47:0];
      end
      3'h1: begin
        attr_id = `SDSB_ID_POWER_ON;
        raw_sel = {16'h0000, power_count[31:0]};
      end
      3'h2: begin
        attr_id = `SDSB_ID_LBA_WR;
        raw_sel = lba_wr_total[`SDSB_LBA_SHIFT+47:`SDSB_LBA_SHIFT];
      end
      3'h3: begin
        attr_id = `SDSB_ID_LBA_RD;
        raw_sel = lba_rd_total[`SDSB_LBA_SHIFT+47:`SDSB_LBA_SHIFT];
      end
      3'h4: begin
        attr_id = `SDSB_ID_ANCHOR;
      end
      3'h5: begin
        attr_id = `SDSB_ID_TRIM;
      end
      default: begin
        attr_id = 8'h00;
      end
    endcase
  end

  assign raw_pos = idx_reg[3:0] - `SDSB_RAW_FIRST;
  assign raw_shift = raw_sel >> {raw_pos[2:0], 3'b000};

  always @* begin
    case (idx_reg[3:0])
      4'h0: attr_byte = attr_id;
      4'h1: attr_byte = `SDSB_FLAGS_LO;
      4'h2: attr_byte = `SDSB_FLAGS_HI;
      4'h3: attr_byte = `SDSB_FIXED_VALUE;
      4'h4: attr_byte = `SDSB_FIXED_VALUE;
      4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA: attr_byte = raw_shift[7:0];
      default: attr_byte = 8'h00;
    endcase
  end

  // ****************************************
  // byte source and end of transfer
  // ****************************************
  wire thr_cmd_ok;
  wire at_last;
  wire [7:0] checksum;
  reg [7:0] byte_src;

  assign thr_cmd_ok = (cmd_feature == `SDSB_FEAT_READ_THRESH) && (cmd_cyl_lo == `SDSB_KEY_CYL_LO) &&
                      (cmd_cyl_hi == `SDSB_KEY_CYL_HI);
  assign at_last = thr_mode_reg ? (idx_reg == `SDSB_SECTOR_LAST) : (idx_reg == `SDSB_ENTRY_LAST);
  assign checksum = 8'h00 - sum_reg;

  always @* begin
    if (!thr_mode_reg) begin
      byte_src = attr_byte;
    end else if (at_last) begin
      byte_src = checksum;
    end else begin
      byte_src = rom_data;
    end
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      idx_reg <= 9'h000;
      thr_mode_reg <= 1'b0;
      sel_reg <= 3'h0;
      sum_reg <= 8'h00;
      busy_reg <= 1'b0;
      cmd_reject_reg <= 1'b0;
      out_data_reg <= 8'h00;
      out_valid_reg <= 1'b0;
      out_last_reg <= 1'b0;
    end else begin
      cmd_reject_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          idx_reg <= 9'h000;
          sum_reg <= 8'h00;
          if (cmd_valid) begin
            if (thr_cmd_ok) begin
              thr_mode_reg <= 1'b1;
              busy_reg <= 1'b1;
              state_reg <= ST_FETCH;
            end else begin
              cmd_reject_reg <= 1'b1;
            end
          end else if (attr_req) begin
            if (attr_sel <= `SDSB_SEL_LAST) begin
              thr_mode_reg <= 1'b0;
              sel_reg <= attr_sel;
              busy_reg <= 1'b1;
              state_reg <= ST_FETCH;
            end else begin
              cmd_reject_reg <= 1'b1;
            end
          end
        end
        ST_FETCH: begin
          // table read of idx_reg lands in rom_data one edge later
          state_reg <= ST_LOAD;
        end
        ST_LOAD: begin
          out_data_reg <= byte_src;
          out_valid_reg <= 1'b1;
          out_last_reg <= at_last;
          sum_reg <= sum_reg + byte_src;
          state_reg <= ST_SEND;
        end
        ST_SEND: begin
          if (out_ready) begin
            out_valid_reg <= 1'b0;
            out_last_reg <= 1'b0;
            if (at_last) begin
              busy_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              idx_reg <= idx_reg + 9'h001;
              state_reg <= ST_FETCH;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          busy_reg <= 1'b0;
          out_valid_reg <= 1'b0;
          out_last_reg <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // health verdict
  // ****************************************
  wire spare_low;
  wire erase_low;
  wire exceeded;

  // only spare and erase-usage take part; advisory counters are never compared
  assign spare_low = spare_value < THR_SPARE;
  assign erase_low = erase_value < THR_ERASE;
  assign exceeded = spare_low | erase_low;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      health_done_reg <= 1'b0;
      health_exceeded_reg <= 1'b0;
      health_cyl_lo_reg <= `SDSB_KEY_CYL_LO;
      health_cyl_hi_reg <= `SDSB_KEY_CYL_HI;
    end else begin
      health_done_reg <= health_req;
      if (health_req) begin
        health_exceeded_reg <= exceeded;
        health_cyl_lo_reg <= exceeded ? `SDSB_BAD_CYL_LO : `SDSB_KEY_CYL_LO;
        health_cyl_hi_reg <= exceeded ? `SDSB_BAD_CYL_HI : `SDSB_KEY_CYL_HI;
      end
    end
  end

endmodule // sdsb_builder

`default_nettype wire

// >>> logic/sdsb_regs.vh
// constants of the health-data sector builder: command codes, identifiers, layout, fixed values
`ifndef SDSB_REGS_VH
`define SDSB_REGS_VH

// ****************************************
// command codes
// ****************************************
`define SDSB_FEAT_READ_THRESH 8'hD1
`define SDSB_KEY_CYL_LO 8'h4F
`define SDSB_KEY_CYL_HI 8'hC2
`define SDSB_BAD_CYL_LO 8'hF4
`define SDSB_BAD_CYL_HI 8'h2C

// ****************************************
// sector layout
// ****************************************
`define SDSB_SECTOR_LAST 9'h1FF
`define SDSB_VERSION_LO 8'h10
`define SDSB_VERSION_HI 8'h00
`define SDSB_ENTRY_BASE 9'h002
`define SDSB_ENTRY_LEN 9'h00C
`define SDSB_ENTRY_SLOTS 9'h01E
`define SDSB_ENTRY_USED 9'h00C
`define SDSB_ENTRY_LAST 9'h00B

// ****************************************
// attribute identifiers
// ****************************************
`define SDSB_ID_SPARE 8'hC4
`define SDSB_ID_SPARE_WORST 8'hD5
`define SDSB_ID_ERASE 8'hE5
`define SDSB_ID_ECC_TOTAL 8'hCB
`define SDSB_ID_ECC_CORR 8'hCC
`define SDSB_ID_CRC 8'hC7
`define SDSB_ID_READS 8'hE8
`define SDSB_ID_POWER_ON 8'h0C
`define SDSB_ID_LBA_WR 8'hF1
`define SDSB_ID_LBA_RD 8'hF2
`define SDSB_ID_ANCHOR 8'hD6
`define SDSB_ID_TRIM 8'hD7

// ****************************************
// attribute entry fields
// ****************************************
`define SDSB_FLAGS_LO 8'h02
`define SDSB_FLAGS_HI 8'h00
`define SDSB_FIXED_VALUE 8'h64
`define SDSB_THR_SPARE_TYP 8'h19
`define SDSB_THR_ERASE_TYP 8'h01
`define SDSB_NO_THRESHOLD 8'h00
`define SDSB_RAW_FIRST 4'h5
`define SDSB_SEL_LAST 3'h5
`define SDSB_LBA_SHIFT 16

`endif

// >>> logic/sdsb_counter.v
// accumulating counter used for the usage statistics
`timescale 1ns/1ps
`default_nettype none

module sdsb_counter #(
  parameter W = 48,
  parameter AW = 16
) (
  input wire clk,
  input wire resetn,
  input wire inc_en,
  input wire [AW-1:0] inc_amt,
  output reg [W-1:0] count_reg
);

  // ****************************************
  // accumulator
  // ****************************************
  wire [W-1:0] count_next;

  assign count_next = count_reg + {{(W-AW){1'b0}}, inc_amt};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= {W{1'b0}};
    end else if (inc_en) begin
      count_reg <= count_next;
    end
  end

endmodule // sdsb_counter

`default_nettype wire

// >>> logic/sdsb_thr_rom.v
// threshold sector table with a registered read port
`timescale 1ns/1ps
`default_nettype none
`include "sdsb_regs.vh"

module sdsb_thr_rom #(
  parameter [7:0] THR_SPARE = `SDSB_THR_SPARE_TYP,
  parameter [7:0] THR_ERASE = `SDSB_THR_ERASE_TYP
) (
  input wire clk,
  input wire resetn,
  input wire [8:0] addr,
  output reg [7:0] rd_data_reg
);

  // ****************************************
  // entry decode
  // ****************************************
  wire [8:0] rel;
  wire [8:0] slot;
  wire [8:0] offs;
  reg [7:0] id;
  reg [7:0] thr;
  reg [7:0] byte_next;

  assign rel = addr - `SDSB_ENTRY_BASE;
  assign slot = rel / `SDSB_ENTRY_LEN;
  assign offs = rel - slot * `SDSB_ENTRY_LEN;

  always @* begin
    case (slot[3:0])
      4'h0: id = `SDSB_ID_SPARE;
      4'h1: id = `SDSB_ID_SPARE_WORST;
      4'h2: id = `SDSB_ID_ERASE;
      4'h3: id = `SDSB_ID_ECC_TOTAL;
      4'h4: id = `SDSB_ID_ECC_CORR;
      4'h5: id = `SDSB_ID_CRC;
      4'h6: id = `SDSB_ID_READS;
      4'h7: id = `SDSB_ID_POWER_ON;
      4'h8: id = `SDSB_ID_LBA_WR;
      4'h9: id = `SDSB_ID_LBA_RD;
      4'hA: id = `SDSB_ID_ANCHOR;
      4'hB: id = `SDSB_ID_TRIM;
      default: id = 8'h00;
    endcase
    case (slot[3:0])
      4'h0: thr = THR_SPARE;
      4'h2: thr = THR_ERASE;
      default: thr = `SDSB_NO_THRESHOLD;
    endcase
    if (addr == 9'h000) begin
      byte_next = `SDSB_VERSION_LO;
    end else if (addr == 9'h001) begin
      byte_next = `SDSB_VERSION_HI;
    end else if (slot >= `SDSB_ENTRY_USED) begin
      byte_next = 8'h00;
    end else if (offs == 9'h000) begin
      byte_next = id;
    end else if (offs == 9'h001) begin
      byte_next = thr;
    end else begin
      byte_next = 8'h00;
    end
  end

  // ****************************************
  // read register
  // ****************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= byte_next;
    end
  end

endmodule // sdsb_thr_rom

`default_nettype wire

// >>> bench/sdsb_builder_sva.sv
// assertions on the ports of the health-data sector builder
`timescale 1ns/1ps
`default_nettype none
module sdsb_builder_sva #(
  parameter [7:0] THR_SPARE = 8'h19,
  parameter [7:0] THR_ERASE = 8'h01
) (
  input wire clk,
  input wire resetn,
  input wire cmd_valid,
  input wire [7:0] cmd_feature,
  input wire [7:0] cmd_cyl_lo,
  input wire [7:0] cmd_cyl_hi,
  input wire busy_reg,
  input wire cmd_reject_reg,
  input wire [7:0] out_data_reg,
  input wire out_valid_reg,
  input wire out_last_reg,
  input wire out_ready,
  input wire [7:0] spare_value,
  input wire [7:0] erase_value,
  input wire health_req,
  input wire health_done_reg,
  input wire health_exceeded_reg,
  input wire [7:0] health_cyl_lo_reg,
  input wire [7:0] health_cyl_hi_reg
);
  // ****************************************
  // properties
  // ****************************************
  wire code_ok = cmd_feature == 8'hD1 && cmd_cyl_lo == 8'h4F && cmd_cyl_hi == 8'hC2;
  wire cmd_go = !busy_reg && cmd_valid && code_ok;
  wire low_val = spare_value < THR_SPARE || erase_value < THR_ERASE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_sector_accept: assert property (cmd_go |=> busy_reg)
    else $error("sector request not taken");
  a_bad_code: assert property (!busy_reg && cmd_valid && !code_ok |=> cmd_reject_reg && !busy_reg)
    else $error("bad code not refused");
  a_version_first: assert property (cmd_go |-> ##3 out_valid_reg && out_data_reg == 8'h10 && !out_last_reg)
    else $error("first byte wrong");
  a_byte_hold: assert property (out_valid_reg && !out_ready |=> out_valid_reg && $stable(out_data_reg)
    && $stable(out_last_reg))
    else $error("byte changed before taken");
  a_byte_pace: assert property (out_valid_reg && out_ready && !out_last_reg |=> !out_valid_reg ##2 out_valid_reg)
    else $error("byte spacing wrong");
  a_last_ends: assert property (out_valid_reg && out_ready && out_last_reg |=> !busy_reg && !out_valid_reg)
    else $error("stream not ended");
  a_health_bad: assert property (health_req && low_val |=> health_done_reg && health_exceeded_reg
    && health_cyl_lo_reg == 8'hF4 && health_cyl_hi_reg == 8'h2C)
    else $error("exceeded verdict wrong");
  a_health_ok: assert property (health_req && !low_val |=> health_done_reg && !health_exceeded_reg
    && health_cyl_lo_reg == 8'h4F && health_cyl_hi_reg == 8'hC2)
    else $error("good verdict wrong");
endmodule // sdsb_builder_sva

bind sdsb_builder sdsb_builder_sva #(.THR_SPARE(THR_SPARE), .THR_ERASE(THR_ERASE)) u_sva (
  .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_feature(cmd_feature), .cmd_cyl_lo(cmd_cyl_lo),
  .cmd_cyl_hi(cmd_cyl_hi), .busy_reg(busy_reg), .cmd_reject_reg(cmd_reject_reg), .out_data_reg(out_data_reg),
  .out_valid_reg(out_valid_reg), .out_last_reg(out_last_reg), .out_ready(out_ready),
  .spare_value(spare_value), .erase_value(erase_value), .health_req(health_req),
  .health_done_reg(health_done_reg), .health_exceeded_reg(health_exceeded_reg),
  .health_cyl_lo_reg(health_cyl_lo_reg), .health_cyl_hi_reg(health_cyl_hi_reg)
);
`default_nettype wire

// >>> bench/sdsb_host_sink.sv
// host model that takes bytes of the sector stream
`timescale 1ns/1ps
`default_nettype none
module sdsb_host_sink (
  input wire logic clk,
  input wire logic resetn,
  input wire logic stall_en,
  output logic out_ready
);
  // ****************************************
  // byte acceptance
  // ****************************************
  // reads the whole sector, at full rate or with random stalls
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= stall_en ? 1'($urandom_range(0, 1)) : 1'b1;
    end
  end
endmodule // sdsb_host_sink
`default_nettype wire

// >>> bench/tb.sv
// self-checking testbench of the health-data sector builder
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, resetn, cmd_valid, attr_req, flash_read_pulse, power_on_pulse;
  logic lba_write_valid, lba_read_valid, health_req, stall;
  logic [7:0] cmd_feature, cmd_cyl_lo, cmd_cyl_hi, spare_value, erase_value;
  logic [2:0] attr_sel;
  logic [15:0] lba_write_count, lba_read_count;
  wire busy_reg, cmd_reject_reg, out_valid_reg, out_last_reg, out_ready, health_done_reg, health_exceeded_reg;
  wire [7:0] out_data_reg, health_cyl_lo_reg, health_cyl_hi_reg;
  int err_count, checks;
  logic [8:0] byte_q[$];
  logic [16:0] hlth_q[$];
  logic rej_q[$];
  logic [47:0] reads;
  logic [31:0] pons;
  logic [63:0] wsum, rsum;
  logic [7:0] ids[12] = '{8'hC4, 8'hD5, 8'hE5, 8'hCB, 8'hCC, 8'hC7, 8'hE8, 8'h0C, 8'hF1, 8'hF2, 8'hD6, 8'hD7};
  logic [7:0] eid[6] = '{8'hE8, 8'h0C, 8'hF1, 8'hF2, 8'hD6, 8'hD7};

  // ****************************************
  // harness and tasks
  // ****************************************
  sdsb_builder uut (
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_feature(cmd_feature), .cmd_cyl_lo(cmd_cyl_lo),
    .cmd_cyl_hi(cmd_cyl_hi), .attr_req(attr_req), .attr_sel(attr_sel), .busy_reg(busy_reg),
    .cmd_reject_reg(cmd_reject_reg), .out_data_reg(out_data_reg), .out_valid_reg(out_valid_reg),
    .out_last_reg(out_last_reg), .out_ready(out_ready), .flash_read_pulse(flash_read_pulse),
    .power_on_pulse(power_on_pulse), .lba_write_valid(lba_write_valid), .lba_write_count(lba_write_count),
    .lba_read_valid(lba_read_valid), .lba_read_count(lba_read_count), .spare_value(spare_value),
    .erase_value(erase_value), .health_req(health_req), .health_done_reg(health_done_reg),
    .health_exceeded_reg(health_exceeded_reg), .health_cyl_lo_reg(health_cyl_lo_reg),
    .health_cyl_hi_reg(health_cyl_hi_reg)
  );
  sdsb_host_sink host (.clk(clk), .resetn(resetn), .stall_en(stall), .out_ready(out_ready));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic fail(input string msg);
    err_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  task automatic cmp_byte(input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) fail($sformatf("byte exp %h got %h", exp, got));
  endtask
  task automatic cmp_health(input logic [16:0] exp, input logic [16:0] got);
    checks++;
    if (got !== exp) fail($sformatf("verdict exp %h got %h", exp, got));
  endtask
  task automatic cmp_rej(input logic exp, input logic got);
    checks++;
    if (got !== exp) fail($sformatf("refusal busy exp %b got %b", exp, got));
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic push_entry(input logic [7:0] id, input logic [47:0] raw);
    logic [7:0] e[12];
    e = '{id, 8'h02, 8'h00, 8'h64, 8'h64, raw[7:0], raw[15:8], raw[23:16], raw[31:24], raw[39:32], raw[47:40], 8'h00};
    foreach (e[i]) byte_q.push_back({i == 11, e[i]});
  endtask
  task automatic push_sector();
    logic [7:0] s[512];
    logic [7:0] sum;
    s = '{default: 8'h00};
    s[0] = 8'h10;
    foreach (ids[k]) s[2 + 12 * k] = ids[k];
    s[3] = 8'h19;
    s[27] = 8'h01;
    sum = 8'h00;
    for (int i = 0; i < 511; i++) sum += s[i];
    s[511] = -sum;
    foreach (s[i]) byte_q.push_back({i == 511, s[i]});
  endtask
  task automatic request(input logic c, input logic [7:0] f, lo, hi, input logic [2:0] sel);
    cmd_valid = c;
    attr_req = !c;
    {cmd_feature, cmd_cyl_lo, cmd_cyl_hi, attr_sel} = {f, lo, hi, sel};
    cyc(1);
    cmd_valid = 1'b0;
    attr_req = 1'b0;
    cyc(1);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while ((busy_reg !== 1'b0 || byte_q.size() > 0) && n < 9000) begin
      cyc(1);
      n++;
    end
    if (n == 9000) fail("stream hang");
  endtask
  task automatic health(input logic [7:0] sp, er);
    logic ex;
    ex = sp < 8'h19 || er < 8'h01;
    hlth_q.push_back({ex, (ex ? 8'hF4 : 8'h4F), (ex ? 8'h2C : 8'hC2)});
    spare_value = sp;
    erase_value = er;
    health_req = 1'b1;
    cyc(1);
    health_req = 1'b0;
    cyc(1);
  endtask
  task automatic traffic(input int n);
    repeat (n) begin
      flash_read_pulse = 1'($urandom_range(0, 1));
      power_on_pulse = $urandom_range(0, 7) == 0;
      {lba_write_valid, lba_read_valid} = 2'($urandom());
      {lba_write_count, lba_read_count} = $urandom();
      reads += flash_read_pulse;
      pons += power_on_pulse;
      if (lba_write_valid) wsum += lba_write_count;
      if (lba_read_valid) rsum += lba_read_count;
      cyc(1);
    end
    {flash_read_pulse, power_on_pulse, lba_write_valid, lba_read_valid} = '0;
  endtask

  always @(posedge clk) begin
    if (resetn && out_valid_reg === 1'b1 && out_ready === 1'b1) begin
      if (byte_q.size() == 0) fail("byte without request");
      else cmp_byte(byte_q.pop_front(), {out_last_reg, out_data_reg});
    end
    if (resetn && cmd_reject_reg === 1'b1) begin
      if (rej_q.size() == 0) fail("refusal without cause");
      else cmp_rej(rej_q.pop_front(), busy_reg);
    end
    if (resetn && health_done_reg === 1'b1) begin
      if (hlth_q.size() == 0) fail("verdict without request");
      else cmp_health(hlth_q.pop_front(), {health_exceeded_reg, health_cyl_lo_reg, health_cyl_hi_reg});
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(15));
    {cmd_valid, attr_req, flash_read_pulse, power_on_pulse, lba_write_valid, lba_read_valid, health_req, stall} = '0;
    {cmd_feature, cmd_cyl_lo, cmd_cyl_hi, attr_sel, lba_write_count, lba_read_count} = '0;
    {spare_value, erase_value, reads, pons, wsum, rsum} = {8'h64, 8'h64, 208'h0};
    resetn = 1'b0;
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    cmp_health({1'b0, 8'h4F, 8'hC2}, {health_exceeded_reg, health_cyl_lo_reg, health_cyl_hi_reg});
    // a refusal only comes while idle, so busy must read low with it
    rej_q = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    request(1, 8'hD0, 8'h4F, 8'hC2, 0);
    request(1, 8'hD1, 8'h4E, 8'hC2, 0);
    request(1, 8'hD1, 8'h4F, 8'hC3, 0);
    request(0, 0, 0, 0, 6);
    request(0, 0, 0, 0, 7);
    for (int r = 0; r < 2; r++) begin
      stall = r[0];
      push_sector();
      request(1, 8'hD1, 8'h4F, 8'hC2, 0);
      request(1, 8'hD1, 8'h4F, 8'hC2, 0);
      request(0, 0, 0, 0, 2);
      wait_idle();
    end
    traffic(400);
    for (int s = 0; s < 6; s++) begin
      push_entry(eid[s], s == 0 ? reads : s == 1 ? {16'h0, pons} : s == 2 ? wsum[63:16] : s == 3 ? rsum[63:16]
        : 48'h0);
      request(0, 0, 0, 0, 3'(s));
      wait_idle();
    end
    health(8'h18, 8'h64);
    health(8'h19, 8'h00);
    health(8'h19, 8'h01);
    repeat (8) health(8'($urandom_range(0, 64)), 8'($urandom_range(0, 3)));
    cyc(4);
    if (byte_q.size() + hlth_q.size() + rej_q.size() != 0) fail("expected results missing");
    finish_test();
  end

  initial begin
    #(60000 * 50);
    fail("watchdog expired");
    finish_test();
  end
endmodule // tb
`default_nettype wire
